// file: src/nva_top.sv
/*
 * serial memory access controller: boot read, expansion rom window
 * with delayed completion, two command registers and a two-wire
 * byte engine with acknowledge polling.
 * assumes all inputs synchronous to i_core_clk and pull-ups outside.
 */
module nva_top
   import nva_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_host_wr,
   input wire logic [7:0] i_host_addr,
   input wire logic [3:0] i_host_be,
   input wire logic [31:0] i_host_wdata,
   output logic [31:0] o_host_rdata,
   input wire logic i_loc_wr,
   input wire logic [7:0] i_loc_addr,
   input wire logic [3:0] i_loc_be,
   input wire logic [31:0] i_loc_wdata,
   output logic [31:0] o_loc_rdata,
   input wire logic i_rom_en,
   input wire logic [31:0] i_rom_base,
   input wire logic i_rom_rd,
   input wire logic i_rom_wr,
   input wire logic [31:0] i_rom_addr,
   output logic o_rom_retry,
   output logic o_rom_trdy,
   output logic [31:0] o_rom_data,
   output logic o_cfg_wr,
   output logic [5:0] o_cfg_addr,
   output logic [7:0] o_cfg_data,
   output logic o_boot_done,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   output logic o_scl,
   output logic o_scl_oe
);
   nva_eng_type st_r;
   nva_own_type own_r, sel;
   logic [8:0] cnt_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r, rdb_r, wd_r, g_wd, h_wd, l_wd;
   logic [10:0] addr_r, g_addr, h_addr, l_addr, boot_addr_r, rom_ofs_r;
   logic [1:0] step_r, s1, rom_cnt_r;
   logic op_rd_r, poll_r, nxt_poll_r, nack_r, fail_r, done_r, lo_r;
   logic g_rd, h_rd, l_rd, h_req, l_req, grant, is_rd, q1, q3, last;
   logic boot_act_r, rom_act_r, rom_full_r, rom_hit, host_hit, loc_hit;
   logic [31:0] h_stat, l_stat, rom_orig_r, rom_buf_r;
   logic [44:0] loc_q;
   logic [10:0] rom_diff;

   // address byte sequence: device code, low address, then data, or the device code again for a read
   function automatic logic [7:0] byte_of(input logic [1:0] s,
      input logic rd, input logic [10:0] a, input logic [7:0] d);
      if (s == 2'h0) byte_of = {DEV_CODE, a[10:8], 1'b0};
      else if (s == 2'h1) byte_of = a[7:0];
      else if (rd) byte_of = {DEV_CODE, a[10:8], 1'b1};
      else byte_of = d;
   endfunction

   // local port retimed; costs latency but keeps it identical
   nva_retime #(.W(45), .STAGES(LOC_STAGES)) u_loc_rt (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_d({i_loc_wr, i_loc_addr, i_loc_be, i_loc_wdata}),
      .o_q(loc_q)
   );

   assign host_hit = i_host_wr && (i_host_addr == REG_OFS);
   assign loc_hit = loc_q[44] && (loc_q[43:36] == REG_OFS);

   nva_cmd_reg u_host (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_wr(host_hit),
      .i_be(i_host_be),
      .i_wdata(i_host_wdata),
      .i_grant(grant && sel == OWN_HOST),
      .i_done(done_r && own_r == OWN_HOST),
      .i_fail(fail_r),
      .i_rdata(rdb_r),
      .o_req(h_req),
      .o_rd(h_rd),
      .o_addr(h_addr),
      .o_wdata(h_wd),
      .o_status(h_stat)
   );

   nva_cmd_reg u_loc (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_wr(loc_hit),
      .i_be(loc_q[35:32]),
      .i_wdata(loc_q[31:0]),
      .i_grant(grant && sel == OWN_LOC),
      .i_done(done_r && own_r == OWN_LOC),
      .i_fail(fail_r),
      .i_rdata(rdb_r),
      .o_req(l_req),
      .o_rd(l_rd),
      .o_addr(l_addr),
      .o_wdata(l_wd),
      .o_status(l_stat)
   );

   // fixed priority: boot, host, local, then rom; each request waits until the engine is free
   always_comb begin
      sel = OWN_NONE;
      g_rd = 1'b1;
      g_addr = boot_addr_r;
      g_wd = h_wd;
      if (boot_act_r) begin
         sel = OWN_BOOT;
      end else if (h_req) begin
         sel = OWN_HOST;
         g_rd = h_rd;
         g_addr = h_addr;
      end else if (l_req) begin
         sel = OWN_LOC;
         g_rd = l_rd;
         g_addr = l_addr;
         g_wd = l_wd;
      end else if (rom_act_r && !rom_full_r) begin
         sel = OWN_ROM;
         g_addr = rom_ofs_r + {9'h000, rom_cnt_r};
      end
   end

   // no grant in the done cycle: owner counters step on that edge
   assign grant = (st_r == E_IDLE) && !done_r && (sel != OWN_NONE);
   assign q1 = cnt_r == SCL_Q1;
   assign q3 = cnt_r == SCL_Q3;
   assign last = cnt_r == SCL_END;
   assign is_rd = op_rd_r && (step_r == 2'h3);
   assign s1 = step_r + 2'h1;

   // serial clock divider, runs only during an operation
   always_ff @(posedge i_core_clk) begin
      if (i_rst || st_r == E_IDLE) cnt_r <= 9'h000;
      else if (last) cnt_r <= 9'h000;
      else cnt_r <= cnt_r + 9'h001;
   end

   // clock low for the first half of each bit, released when idle
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_scl_oe <= 1'b0;
         lo_r <= 1'b0;
      end else begin
         o_scl_oe <= (st_r != E_IDLE) && (cnt_r < SCL_HALF);
         lo_r <= 1'b0;
      end
   end

   // byte engine: start, bytes with ack, repeated start, stop, poll
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         st_r <= E_IDLE;
         own_r <= OWN_NONE;
         o_sda_oe <= 1'b0;
         {op_rd_r, poll_r, nxt_poll_r, nack_r, fail_r, done_r} <= '0;
         {bit_r, step_r, sh_r, rdb_r, wd_r, addr_r} <= '0;
      end else begin
         done_r <= 1'b0;
         case (st_r)
            E_IDLE: begin
               o_sda_oe <= 1'b0;
               if (grant) begin
                  own_r <= sel;
                  op_rd_r <= g_rd;
                  addr_r <= g_addr;
                  wd_r <= g_wd;
                  step_r <= 2'h0;
                  poll_r <= 1'b0;
                  fail_r <= 1'b0;
                  st_r <= E_START;
               end
            end
            E_START: begin
               if (q1) o_sda_oe <= 1'b0;
               if (q3) o_sda_oe <= 1'b1; // data falls, clock high
               if (last) begin
                  st_r <= E_BYTE;
                  bit_r <= 4'h0;
                  sh_r <= byte_of(step_r, op_rd_r, addr_r, wd_r);
               end
            end
            E_BYTE: begin
               if (q1) o_sda_oe <= (bit_r != BIT_ACK) && !is_rd && !sh_r[7];
               if (q3 && bit_r != BIT_ACK) rdb_r <= {rdb_r[6:0], i_sda};
               if (q3 && bit_r == BIT_ACK) nack_r <= i_sda;
               if (last && bit_r != BIT_ACK) begin
                  bit_r <= bit_r + 4'h1;
                  sh_r <= {sh_r[6:0], 1'b0};
               end else if (last) begin
                  bit_r <= 4'h0;
                  nxt_poll_r <= 1'b0;
                  if (is_rd || poll_r) begin
                     st_r <= E_STOP; // master leaves read byte unacked
                     nxt_poll_r <= poll_r && nack_r;
                  end else if (nack_r) begin
                     st_r <= E_STOP;
                     fail_r <= 1'b1;
                  end else if (!op_rd_r && step_r == 2'h2) begin
                     st_r <= E_STOP;
                     nxt_poll_r <= 1'b1;
                  end else begin
                     step_r <= s1;
                     sh_r <= byte_of(s1, op_rd_r, addr_r, wd_r);
                     if (op_rd_r && step_r == 2'h1) st_r <= E_START;
                  end
               end
            end
            E_STOP: begin
               if (q1) o_sda_oe <= 1'b1;
               if (q3) o_sda_oe <= 1'b0; // data rises, clock high
               if (last && nxt_poll_r) begin
                  poll_r <= 1'b1;
                  step_r <= 2'h0;
                  st_r <= E_START;
               end else if (last) begin
                  st_r <= E_IDLE;
                  done_r <= 1'b1;
               end
            end
            default: st_r <= E_IDLE;
         endcase
      end
   end

   // boot read of the configuration image, stops on a missing memory
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         boot_act_r <= 1'b1;
         boot_addr_r <= BOOT_FIRST;
         o_boot_done <= 1'b0;
         o_cfg_wr <= 1'b0;
         o_cfg_addr <= 6'h00;
         o_cfg_data <= 8'h00;
      end else begin
         o_cfg_wr <= 1'b0;
         if (done_r && own_r == OWN_BOOT) begin
            o_cfg_wr <= !fail_r;
            o_cfg_addr <= addr_r[5:0];
            o_cfg_data <= rdb_r;
            boot_addr_r <= boot_addr_r + 11'h001;
            if (fail_r || addr_r == BOOT_LAST) begin
               boot_act_r <= 1'b0;
               o_boot_done <= 1'b1;
            end
         end
      end
   end

   // rom window: 2K aligned, offset rounded down to a word
   assign rom_hit = i_rom_en &&
      (i_rom_addr[31:ADDR_W] == i_rom_base[31:ADDR_W]);
   assign rom_diff = i_rom_addr[10:0] - i_rom_base[10:0];

   // delayed read: one held transaction, retried until it matches
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         {o_rom_retry, o_rom_trdy, rom_act_r, rom_full_r} <= '0;
         {rom_cnt_r, rom_ofs_r, rom_orig_r, rom_buf_r, o_rom_data} <= '0;
      end else begin
         o_rom_retry <= 1'b0;
         o_rom_trdy <= 1'b0;
         if (rom_hit && i_rom_wr) begin
            o_rom_trdy <= 1'b1;
         end else if (rom_hit && i_rom_rd) begin
            if (rom_full_r && i_rom_addr == rom_orig_r) begin
               o_rom_trdy <= 1'b1;
               o_rom_data <= rom_buf_r;
               rom_act_r <= 1'b0;
               rom_full_r <= 1'b0;
            end else begin
               o_rom_retry <= 1'b1;
               if (!rom_act_r) begin
                  rom_act_r <= 1'b1;
                  rom_orig_r <= i_rom_addr;
                  rom_ofs_r <= {rom_diff[10:2], 2'b00};
                  rom_cnt_r <= 2'h0;
               end
            end
         end
         if (done_r && own_r == OWN_ROM) begin
            rom_buf_r[rom_cnt_r*8+:8] <= rdb_r;
            rom_cnt_r <= rom_cnt_r + 2'h1;
            if (rom_cnt_r == ROM_LAST) rom_full_r <= 1'b1;
         end
      end
   end

   // register read data and open-drain low level, all from flops
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_host_rdata <= 32'h0000_0000;
         o_loc_rdata <= 32'h0000_0000;
      end else begin
         o_host_rdata <= h_stat;
         o_loc_rdata <= l_stat;
      end
   end
   assign o_sda = lo_r;
   assign o_scl = lo_r;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence stop_poll_s;
      st_r == E_STOP && last && nxt_poll_r;
   endsequence
   sequence restart_s;
      st_r == E_START && poll_r ##1 st_r == E_START;
   endsequence
   ack_poll_a: assert property (stop_poll_s |=> restart_s)
      else $error("acknowledge poll not restarted");
   scl_period_a: assert property (
      st_r != E_IDLE && cnt_r == 9'h000 |-> ##293 cnt_r == 9'h000)
      else $error("serial clock period wrong");
   bus_release_a: assert property (st_r == E_IDLE
      |=> !o_sda_oe && !o_scl_oe) else $error("lines held while idle");
   boot_load_a: assert property (
      done_r && own_r == OWN_BOOT && !fail_r
      |=> o_cfg_wr && o_cfg_addr == $past(addr_r[5:0])
      && $past(addr_r) >= BOOT_FIRST && $past(addr_r) <= BOOT_LAST)
      else $error("boot byte not delivered");
   rom_first_a: assert property (
      rom_hit && i_rom_rd && !i_rom_wr && !rom_act_r
      |=> o_rom_retry && !o_rom_trdy && rom_act_r)
      else $error("first rom read not retried");
   rom_match_a: assert property (o_rom_trdy && !$past(i_rom_wr)
      |-> $past(rom_full_r) && $past(i_rom_addr) == $past(rom_orig_r))
      else $error("rom read completed early");
   rom_drop_a: assert property (
      rom_hit && i_rom_wr && !rom_act_r |=> o_rom_trdy && !rom_act_r)
      else $error("rom write not dropped");
   rom_four_a: assert property ($rose(rom_full_r)
      |-> rom_cnt_r == 2'h0 && $past(rom_cnt_r) == ROM_LAST)
      else $error("rom word not four bytes");
   nack_fail_a: assert property (
      st_r == E_BYTE && last && bit_r == BIT_ACK && nack_r
      && !poll_r && !is_rd |=> fail_r && st_r == E_STOP)
      else $error("no-ack not flagged");
endmodule

// file: src/nva_pkg.sv
/*
 * shared constants for the serial memory access controller: register
 * layout, command codes, state encodings and serial clock timing.
 * assumes one core clock; every file imports the whole package.
 */
package nva_pkg;
   // command/status register layout, same offset on both ports
   localparam logic [7:0] REG_OFS = 8'h3c;
   localparam int CMD_LO = 29;
   localparam int FAIL_BIT = 28;
   localparam int DAT_LO = 16;
   localparam int BE_CMD = 3;
   localparam int BE_DAT = 2;
   // command field codes
   localparam logic [2:0] CMD_LOW = 3'h4;
   localparam logic [2:0] CMD_HIGH = 3'h5;
   localparam logic [2:0] CMD_WRITE = 3'h6;
   localparam logic [2:0] CMD_READ = 3'h7;
   // memory addressing
   localparam int ADDR_W = 11;
   localparam logic [3:0] DEV_CODE = 4'ha;
   localparam logic [10:0] BOOT_FIRST = 11'h040;
   localparam logic [10:0] BOOT_LAST = 11'h07f;
   localparam logic [1:0] ROM_LAST = 2'h3;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // serial clock: core clock divided by 293
   localparam logic [8:0] SCL_DIV = 9'h125;
   localparam logic [8:0] SCL_Q1 = SCL_DIV / 9'h4;
   localparam logic [8:0] SCL_HALF = SCL_DIV / 9'h2;
   localparam logic [8:0] SCL_Q3 = SCL_Q1 + SCL_HALF;
   localparam logic [8:0] SCL_END = SCL_DIV - 9'h1;
   // retiming depth of the local port
   localparam int LOC_STAGES = 2;
   typedef enum logic [1:0] {
      STB_NONE = 2'b00,
      STB_LOW = 2'b01,
      STB_HIGH = 2'b10,
      STB_WDATA = 2'b11
   } nva_strobe_type;
   typedef enum logic [1:0] {
      E_IDLE = 2'b00,
      E_START = 2'b01,
      E_BYTE = 2'b10,
      E_STOP = 2'b11
   } nva_eng_type;
   typedef enum logic [2:0] {
      OWN_NONE = 3'b000,
      OWN_BOOT = 3'b001,
      OWN_HOST = 3'b010,
      OWN_LOC = 3'b011,
      OWN_ROM = 3'b100
   } nva_own_type;
endpackage

// file: src/nva_retime.sv
/*
 * fixed-depth retiming pipeline for the local register port.
 * assumes the local side is already synchronous to the core clock.
 */
module nva_retime
   import nva_pkg::*;
#(
   parameter int W = 1,
   parameter int STAGES = LOC_STAGES
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] pipe_r [STAGES];

   // one flop per stage; adds latency, never drops a write
   for (genvar g = 0; g < STAGES; g++) begin : g_stage
      always_ff @(posedge i_core_clk) begin
         if (i_rst) begin
            pipe_r[g] <= '0;
         end else if (g == 0) begin
            pipe_r[g] <= i_d;
         end else begin
            pipe_r[g] <= pipe_r[(g == 0) ? 0 : g - 1];
         end
      end
   end

   assign o_q = pipe_r[STAGES-1];
endmodule

// file: src/nva_cmd_reg.sv
/*
 * one command/status register: load strobes, address and data
 * holding registers, busy and no-ack flags, pending request.
 * assumes a single word write with byte enables per access.
 */
module nva_cmd_reg
   import nva_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_wr,
   input wire logic [3:0] i_be,
   input wire logic [31:0] i_wdata,
   input wire logic i_grant,
   input wire logic i_done,
   input wire logic i_fail,
   input wire logic [7:0] i_rdata,
   output logic o_req,
   output logic o_rd,
   output logic [10:0] o_addr,
   output logic [7:0] o_wdata,
   output logic [31:0] o_status
);
   nva_strobe_type stb_r, eff;
   logic [7:0] alo_r, wd_r, dbyte_r;
   logic [2:0] ahi_r, cmd;
   logic busy_r, sent_r, rd_r, fail_r, cmd_ok, dat_ok, begin_c;

   // command decode shared by strobe update and data steering
   function automatic nva_strobe_type stb_of(input logic [2:0] c);
      if (!c[2]) stb_of = STB_WDATA;
      else if (c == CMD_LOW) stb_of = STB_LOW;
      else if (c == CMD_HIGH) stb_of = STB_HIGH;
      else stb_of = STB_NONE;
   endfunction

   // commands are ignored while busy, software waits for ready
   assign cmd = i_wdata[CMD_LO+:3];
   assign cmd_ok = i_wr && i_be[BE_CMD] && !busy_r;
   assign dat_ok = i_wr && i_be[BE_DAT] && !busy_r;
   assign begin_c = cmd_ok && cmd[2] && cmd[1];
   // a wide write applies its command before its data byte
   assign eff = !cmd_ok ? stb_r :
      (cmd == CMD_WRITE) ? STB_WDATA : stb_of(cmd);

   // only one load strobe at a time, encoded so
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         stb_r <= STB_NONE;
      end else if (cmd_ok) begin
         stb_r <= stb_of(cmd);
      end
   end

   // data byte goes where the strobe points
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         alo_r <= 8'h00;
         ahi_r <= 3'h0;
         wd_r <= 8'h00;
      end else if (dat_ok) begin
         if (eff == STB_LOW) alo_r <= i_wdata[DAT_LO+:8];
         else if (eff == STB_HIGH) ahi_r <= i_wdata[DAT_LO+:3];
         else if (eff == STB_WDATA) wd_r <= i_wdata[DAT_LO+:8];
      end
   end

   // busy, launch and result flags
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         busy_r <= 1'b0;
         sent_r <= 1'b0;
         rd_r <= 1'b0;
         fail_r <= 1'b0;
         dbyte_r <= 8'h00;
      end else begin
         if (begin_c) begin
            busy_r <= 1'b1;
            sent_r <= 1'b0;
            rd_r <= cmd[0];
            fail_r <= 1'b0;
         end else if (i_done) begin
            busy_r <= 1'b0;
            fail_r <= i_fail;
         end
         if (i_grant) sent_r <= 1'b1;
         if (i_done && rd_r) dbyte_r <= i_rdata;
         else if (dat_ok) dbyte_r <= i_wdata[DAT_LO+:8];
      end
   end

   assign o_req = busy_r && !sent_r;
   assign o_rd = rd_r;
   assign o_addr = {ahi_r, alo_r};
   assign o_wdata = wd_r;
   assign o_status = {busy_r, 2'b00, fail_r, 4'h0, dbyte_r, 16'h0000};

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   low_strobe_a: assert property (cmd_ok && cmd == CMD_LOW
      |=> stb_r == STB_LOW) else $error("low strobe not taken");
   low_load_a: assert property (
      dat_ok && !(i_wr && i_be[BE_CMD]) && stb_r == STB_LOW
      |=> o_addr[7:0] == $past(i_wdata[23:16])
      && stb_r == STB_LOW) else $error("low address not loaded");
   wdata_strobe_a: assert property (cmd_ok && !cmd[2]
      |=> stb_r == STB_WDATA [*1] ##1 1) else $error("data strobe lost");
   begin_write_a: assert property (begin_c && !cmd[0]
      |=> busy_r && o_req && stb_r == STB_NONE && !o_rd)
      else $error("write not launched");
   fail_hold_a: assert property (i_done && i_fail
      |=> o_status[28] && !o_status[31]) else $error("no-ack lost");
   read_back_a: assert property (i_done && rd_r
      |=> o_status[23:16] == $past(i_rdata)) else $error("read byte lost");
endmodule

// file: test/nva_mem_model.sv
/*
 * two-wire serial memory model, 2k bytes, deaf while writing.
 * assumes pull-ups: the bench resolves the wires from every pull.
 */
module nva_mem_model
   import nva_pkg::*;
(
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_present,
   output logic o_pull
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [2048];
   logic [7:0] sh;
   logic [10:0] ptr;
   int n = 0, ph = 4, polls = 0;
   bit lead, more, wrote;
   initial o_pull = 0;
   // start condition opens a frame
   always @(negedge i_sda) if (i_scl) {n, ph} = 0;
   // stop after a stored byte: the next two polls go unanswered
   always @(posedge i_sda)
      if (i_scl && wrote) begin
         polls = 2;
         wrote = 0;
      end
   // bits enter on the rising clock, the ninth is the master's ack
   always @(posedge i_scl) begin
      if (n < 8) sh = {sh[6:0], i_sda};
      else more = !i_sda;
      n++;
   end
   // answers move only while the clock is low
   always @(negedge i_scl) begin
      o_pull = 0;
      if (n == 8 && ph == 0) begin
         o_pull = i_present && polls == 0 && sh[7:4] == DEV_CODE;
         if (polls > 0) polls--;
         {ptr[10:8], lead} = {sh[3:1], 1'h1};
         ph = !o_pull ? 4 : sh[0] ? 3 : 1;
      end else if (n == 8 && ph < 3) begin
         if (ph == 1) ptr[7:0] = sh;
         else mem[ptr] = sh;
         wrote = ph == 2;
         ph = 2;
         o_pull = 1;
      end else if (n == 9) begin
         n = 0;
         if (ph == 3 && !lead && more) ptr++;
         else if (ph == 3 && !lead) ph = 4; // released so a stop can follow
         lead = 0;
         o_pull = ph == 3 && !mem[ptr][7];
      end else if (ph == 3 && n > 0 && n < 8) o_pull = !mem[ptr][7 - n];
   end
endmodule

// file: test/nva_top_bench.sv
/*
 * self-checking bench for the serial memory access controller.
 * assumes one clock; the memory model answers on the two-wire bus.
 */
module nva_top_bench
   import nva_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, i_host_wr = 0, i_loc_wr = 0, i_rom_en = 0;
   logic i_rom_rd = 0, i_rom_wr = 0, present = 0, pull, scl_q, i_sda;
   logic sda_q, sda_lv, scl_lv;
   logic [7:0] ofs = REG_OFS;
   logic [3:0] i_host_be = 0, i_loc_be = 0;
   logic [31:0] i_host_wdata = 0, i_loc_wdata = 0, i_rom_base = 0;
   logic [31:0] i_rom_addr = 0, o_host_rdata, o_loc_rdata, o_rom_data;
   logic o_rom_retry, o_rom_trdy, o_cfg_wr, o_boot_done, o_sda_oe, o_scl_oe;
   logic [7:0] ref_mem [2048];
   int bad_count = 0, total_checks = 0, cfg_seen = 0, last = -1000, cyc = 0;
   // open-drain data wire with its pull-up
   assign i_sda = !(o_sda_oe || pull);
   nva_top i_dut (.i_core_clk(clk), .i_rst(rst), .i_host_wr,
      .i_host_addr(ofs), .i_host_be, .i_host_wdata, .o_host_rdata,
      .i_loc_wr, .i_loc_addr(ofs), .i_loc_be, .i_loc_wdata, .o_loc_rdata,
      .i_rom_en, .i_rom_base, .i_rom_rd, .i_rom_wr, .i_rom_addr, .o_rom_retry,
      .o_rom_trdy, .o_rom_data, .o_cfg_wr, .o_cfg_addr(), .o_cfg_data(),
      .o_boot_done, .i_sda, .o_sda(sda_lv), .o_sda_oe, .o_scl(scl_lv),
      .o_scl_oe);
   nva_mem_model i_mem (.i_scl(!o_scl_oe), .i_sda, .i_present(present),
      .o_pull(pull));
   initial forever #2 clk = ~clk;
   // boot deliveries and serial clock spacing inside frames
   always @(negedge clk) begin
      cyc++;
      cfg_seen += int'(o_cfg_wr === 1'b1);
      if (scl_q === 1'b1 && o_scl_oe === 1'b0) begin
         if (cyc - last < 400) chk(cyc - last, 293);
         last = cyc;
      end
      // a stop closes the frame; the idle gap is not a clock period
      if (o_scl_oe === 1'b0 && sda_q === 1'b0 && i_sda === 1'b1)
         last = -1000;
      scl_q = o_scl_oe;
      sda_q = i_sda;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (bad_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one register write pulse, host port (p=0) or local port (p=1)
   task automatic wr(input bit p, input logic [3:0] be, input logic [31:0] d);
      @(negedge clk);
      {i_host_wr, i_host_be, i_host_wdata} = {!p, be, d};
      {i_loc_wr, i_loc_be, i_loc_wdata} = {p, be, d};
      @(negedge clk);
      {i_host_wr, i_loc_wr} = 2'h0;
   endtask
   // one rom attempt; its one-cycle answer is in view on return
   task automatic rom(input bit w, input logic [31:0] a);
      @(negedge clk);
      {i_rom_wr, i_rom_rd, i_rom_addr} = {w, !w, a};
      @(negedge clk);
      {i_rom_wr, i_rom_rd} = 2'h0;
   endtask
   task automatic wait_idle(input bit p);
      int i;
      for (i = 0; i < 90000; i++) begin
         if ((p ? o_loc_rdata[31] : o_host_rdata[31]) === 1'b0) return;
         @(negedge clk);
      end
      bad_count++;
      close_out();
   endtask
   initial begin
      int a, a2, o, i;
      logic [7:0] d;
      logic [31:0] ra;
      void'($urandom(21554));
      for (i = 0; i < 2048; i++) begin
         ref_mem[i] = $urandom;
         i_mem.mem[i] = ref_mem[i];
      end
      repeat (8) @(negedge clk);
      rst = 0;
      // no memory answers: boot gives up with nothing delivered
      for (i = 0; i < 20000 && o_boot_done !== 1'b1; i++) @(negedge clk);
      chk(o_boot_done, 1);
      chk(cfg_seen, 0);
      // writes at another offset are ignored on both ports
      ofs = 8'h38;
      wr(0, 4'h8, 32'he000_0000);
      wr(1, 4'h8, 32'he000_0000);
      repeat (4) @(negedge clk);
      chk({o_host_rdata[31], o_loc_rdata[31]}, 2'h0);
      ofs = REG_OFS;
      // byte-wide host write, low address overwritten, high spare bits set
      present = 1;
      a = $urandom_range(2047);
      d = $urandom;
      wr(0, 4'h8, 32'h8000_0000);
      wr(0, 4'h4, 32'h00ff_0000);
      wr(0, 4'h4, {8'h0, a[7:0], 16'h0});
      wr(0, 4'hc, {3'h5, 5'h0, 5'h1f, a[10:8], 16'h0});
      wr(0, 4'h8, 32'h0);
      wr(0, 4'h4, {8'h0, d, 16'h0});
      wr(0, 4'h8, 32'hc000_0000);
      // two-byte-wide local read queued behind the host write
      a2 = $urandom_range(2047);
      wr(1, 4'hc, {3'h4, 5'h0, a2[7:0], 16'h0});
      wr(1, 4'hc, {3'h5, 10'h0, a2[10:8], 16'h0});
      wr(1, 4'h8, 32'he000_0000);
      repeat (4) @(negedge clk);
      chk(o_host_rdata[31], 1);
      chk(o_loc_rdata[31], 1);
      wait_idle(0);
      ref_mem[a] = d;
      chk(i_mem.polls, 0);
      chk(i_mem.mem[a], d);
      chk(o_host_rdata[28], 0);
      chk(o_loc_rdata[31], 1);
      wait_idle(1);
      chk(o_loc_rdata[23:16], ref_mem[a2]);
      // read with no memory present
      present = 0;
      wr(0, 4'h8, 32'he000_0000);
      repeat (4) @(negedge clk);
      wait_idle(0);
      chk(o_host_rdata[28], 1);
      // rom window: dropped write, then a delayed read beside a register read
      present = 1;
      i_rom_en = 1;
      i_rom_base = $urandom & 32'hffff_f800;
      ra = i_rom_base | ($urandom & 32'h7ff);
      rom(1, ra);
      chk({o_rom_retry, o_rom_trdy}, 2'h1);
      repeat (20) @(negedge clk);
      chk(o_scl_oe, 0);
      chk(o_host_rdata[28], 1);
      rom(0, ra);
      chk({o_rom_retry, o_rom_trdy}, 2'h2);
      wr(0, 4'h8, 32'he000_0000);
      repeat (4) @(negedge clk);
      wait_idle(0);
      chk(o_host_rdata[28], 0);
      chk(o_host_rdata[23:16], ref_mem[a]);
      for (i = 0; i < 200 && o_rom_trdy !== 1'b1; i++) begin
         rom(0, ra ^ 32'h4);
         chk({o_rom_retry, o_rom_trdy}, 2'h2);
         rom(0, ra);
         chk(o_rom_retry ^ o_rom_trdy, 1);
         if (o_rom_trdy !== 1'b1) repeat (300) @(negedge clk);
      end
      chk(o_rom_trdy, 1);
      o = ra[10:0] & 11'h7fc;
      chk(o_rom_data, {ref_mem[o + 3], ref_mem[o + 2], ref_mem[o + 1],
         ref_mem[o]});
      repeat (300) @(negedge clk);
      chk({o_sda_oe, o_scl_oe}, 2'h0);
      chk({sda_lv, scl_lv}, 2'h0);
      close_out();
   end
endmodule
